// [core/dfp_pkg.sv]
// constants, types and register map of the debug flash data port
// Summary of operation
// RL1: 8-bit flash data register at debug address 0xb4, reset to zero.
// RL2: command byte 0x06 block read, 0x07 block write, 0x03 device erase.
// RL3: debug link works while halted; peripherals and program stay stalled.
// RL4: halted: reset pin is debug clock, port pin is data; else user owns.
// RL5: the shared reset pin is input only and never driven.
// RL6: link is a host-driven clock plus one two-way data line.
// RL7: address select register picks the target of data read and write.
// RL8: command byte 0x08 starts an erase of one flash page.
package dfp_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] DFP_ADDR_FLASH_DATA = 8'hb4;
  localparam logic [7:0] DFP_RST_FLASH_DATA = 8'h00;
  localparam logic [7:0] DFP_RST_ADDR_SEL = 8'h00;
  localparam logic [7:0] DFP_UNMAPPED_VAL = 8'h00;
  // ---------------------------------------------------------------
  // flash commands
  // ---------------------------------------------------------------
  localparam logic [7:0] DFP_CMD_BLOCK_READ = 8'h06;
  localparam logic [7:0] DFP_CMD_BLOCK_WRITE = 8'h07;
  localparam logic [7:0] DFP_CMD_PAGE_ERASE = 8'h08;
  localparam logic [7:0] DFP_CMD_DEVICE_ERASE = 8'h03;
  // ---------------------------------------------------------------
  // link framing
  // ---------------------------------------------------------------
  localparam logic [1:0] DFP_INS_DATA_READ = 2'h0;
  localparam logic [1:0] DFP_INS_DATA_WRITE = 2'h1;
  localparam logic [1:0] DFP_INS_ADDR_READ = 2'h2;
  localparam logic [1:0] DFP_INS_ADDR_WRITE = 2'h3;
  localparam logic [2:0] DFP_INS_LAST = 3'h1;
  localparam logic [2:0] DFP_DATA_LAST = 3'h7;
  localparam logic [2:0] DFP_CNT_ZERO = 3'h0;
  localparam logic [2:0] DFP_CNT_ONE = 3'h1;
  typedef enum logic [1:0] {
    DFP_ST_IDLE = 2'b00,
    DFP_ST_INS = 2'b01,
    DFP_ST_DATA = 2'b11,
    DFP_ST_STOP = 2'b10
  } dfp_state_t;
  typedef enum logic [2:0] {
    DFP_FC_NONE = 3'h0,
    DFP_FC_READ = 3'h1,
    DFP_FC_WRITE = 3'h2,
    DFP_FC_PAGE_ERASE = 3'h3,
    DFP_FC_DEVICE_ERASE = 3'h4
  } dfp_fcmd_t;
endpackage

// [core/dfp_debug_port.sv]
// two-wire debug link slave with flash programming data register
module dfp_debug_port (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic halted,
  input wire logic debug_link_clock,
  input wire logic debug_link_data_in,
  output logic debug_link_data_out,
  output logic debug_link_data_oe,
  output logic user_reset_n,
  input wire logic user_port_out,
  input wire logic user_port_oe,
  output logic user_port_in,
  output dfp_pkg::dfp_fcmd_t flash_cmd,
  output logic flash_cmd_start,
  output logic [7:0] flash_byte,
  output logic flash_byte_wr,
  input wire logic flash_rd_valid,
  input wire logic [7:0] flash_rd_byte,
  input wire logic flash_cmd_done,
  output logic [7:0] debug_address_select
);
  import dfp_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] ck_q, ck_d;
  logic [1:0] dt_q, dt_d;
  // oversampled link clock: a high or low phase shorter than one mclk can be lost
  always_comb begin
    ck_d = {ck_q[1:0], debug_link_clock};
    dt_d = {dt_q[0], debug_link_data_in};
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ck_q <= 3'h0;
      dt_q <= 2'h0;
    end else begin
      ck_q <= ck_d;
      dt_q <= dt_d;
    end
  end
  // only stages 1 and 2 feed logic; stage 0 is read by stage 1 alone
  logic rise;
  logic bit_in;
  assign rise = ck_q[1] & ~ck_q[2] & halted; // [RL3]
  assign bit_in = dt_q[1];

  // ---------------------------------------------------------------
  // link framing and registers
  // ---------------------------------------------------------------
  dfp_state_t st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  logic [1:0] ins_q, ins_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] addr_q, addr_d;
  logic [7:0] fdat_q, fdat_d;
  logic drive_q, drive_d;
  dfp_fcmd_t fc_q, fc_d;
  logic busy_q, busy_d;
  logic cst_q, cst_d;
  logic bwr_q, bwr_d;
  logic [7:0] fb_q, fb_d;

  function automatic logic [7:0] rd_sel(input logic [7:0] a,
                                        input logic [7:0] fd);
    rd_sel = (a == DFP_ADDR_FLASH_DATA) ? fd : DFP_UNMAPPED_VAL;
  endfunction

  function automatic dfp_fcmd_t decode(input logic [7:0] b);
    case (b)
      DFP_CMD_BLOCK_READ: decode = DFP_FC_READ; // [RL2]
      DFP_CMD_BLOCK_WRITE: decode = DFP_FC_WRITE; // [RL2]
      DFP_CMD_DEVICE_ERASE: decode = DFP_FC_DEVICE_ERASE; // [RL2]
      DFP_CMD_PAGE_ERASE: decode = DFP_FC_PAGE_ERASE; // [RL8]
      default: decode = DFP_FC_NONE;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // command decode of the received byte
  // ---------------------------------------------------------------
  dfp_fcmd_t dec;
  logic dec_ok;
  assign dec = decode(sh_q);
  assign dec_ok = (dec != DFP_FC_NONE);

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    ins_d = ins_q;
    sh_d = sh_q;
    addr_d = addr_q;
    fdat_d = fdat_q;
    drive_d = drive_q;
    fc_d = fc_q;
    busy_d = busy_q;
    cst_d = 1'b0;
    bwr_d = 1'b0;
    fb_d = fb_q;
    // flash side returns read bytes into the data register [RL1]
    // a link write in the same cycle is assigned later and wins
    if (flash_rd_valid) begin
      fdat_d = flash_rd_byte;
    end
    if (flash_cmd_done) begin
      busy_d = 1'b0;
    end
    if (!halted) begin
      // a frame cut by leaving halt is dropped and the pin released
      st_d = DFP_ST_IDLE;
      drive_d = 1'b0;
    end else if (rise) begin
      case (st_q)
        DFP_ST_IDLE: begin
          // a high line under a clock edge is an idle bit, not a start
          if (!bit_in) begin
            st_d = DFP_ST_INS;
            cnt_d = DFP_CNT_ZERO;
          end
        end
        DFP_ST_INS: begin
          ins_d = {bit_in, ins_q[1]};
          cnt_d = cnt_q + DFP_CNT_ONE;
          if (cnt_q == DFP_INS_LAST) begin
            st_d = DFP_ST_DATA;
            cnt_d = DFP_CNT_ZERO;
            if (ins_q[1] == 1'b0) begin
              // read: load the selected register, lsb leaves first
              drive_d = 1'b1;
              sh_d = bit_in ? addr_q : rd_sel(addr_q, fdat_q); // [RL7]
            end
          end
        end
        DFP_ST_DATA: begin
          // during a read the line carries our own bit back in
          cnt_d = cnt_q + DFP_CNT_ONE;
          sh_d = {bit_in, sh_q[7:1]};
          if (cnt_q == DFP_DATA_LAST) begin
            st_d = DFP_ST_STOP;
            drive_d = 1'b0;
          end
        end
        DFP_ST_STOP: begin
          // effects wait for the stop edge, so a cut frame changes nothing
          st_d = DFP_ST_IDLE;
          case (ins_q)
            DFP_INS_ADDR_WRITE: addr_d = sh_q; // [RL7]
            DFP_INS_DATA_WRITE: begin
              if (addr_q == DFP_ADDR_FLASH_DATA) begin
                fdat_d = sh_q; // [RL1]
                if (!busy_q) begin
                  // with done in the same cycle, the new command keeps busy
                  fc_d = dec;
                  cst_d = dec_ok;
                  busy_d = dec_ok;
                end else begin
                  // later bytes carry address and data to the flash
                  bwr_d = 1'b1;
                  fb_d = sh_q;
                end
              end
            end
            default: begin
            end
          endcase
        end
        default: st_d = DFP_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= DFP_ST_IDLE;
      cnt_q <= DFP_CNT_ZERO;
      ins_q <= DFP_INS_DATA_READ;
      sh_q <= DFP_RST_FLASH_DATA;
      addr_q <= DFP_RST_ADDR_SEL;
      fdat_q <= DFP_RST_FLASH_DATA; // [RL1]
      drive_q <= 1'b0;
      fc_q <= DFP_FC_NONE;
      busy_q <= 1'b0;
      cst_q <= 1'b0;
      bwr_q <= 1'b0;
      fb_q <= DFP_RST_FLASH_DATA;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      ins_q <= ins_d;
      sh_q <= sh_d;
      addr_q <= addr_d;
      fdat_q <= fdat_d;
      drive_q <= drive_d;
      fc_q <= fc_d;
      busy_q <= busy_d;
      cst_q <= cst_d;
      bwr_q <= bwr_d;
      fb_q <= fb_d;
    end
  end

  // ---------------------------------------------------------------
  // pin sharing
  // ---------------------------------------------------------------
  // the clock pin has no output path at all, so it can never be driven
  assign user_reset_n = halted | ck_q[1]; // [RL4] [RL5]
  assign user_port_in = bit_in;
  always_comb begin
    if (halted) begin
      debug_link_data_oe = drive_q; // [RL4] [RL6]
      debug_link_data_out = sh_q[0];
    end else begin
      debug_link_data_oe = user_port_oe; // [RL4]
      debug_link_data_out = user_port_out;
    end
  end
  assign flash_cmd = fc_q;
  assign flash_cmd_start = cst_q;
  assign flash_byte = fb_q;
  assign flash_byte_wr = bwr_q;
  assign debug_address_select = addr_q;
endmodule

// [bench/dfp_debug_port_props.sv]
// concurrent checks on the ports of the debug flash data port
module dfp_debug_port_props (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic halted,
  input wire logic debug_link_clock,
  input wire logic debug_link_data_out,
  input wire logic debug_link_data_oe,
  input wire logic user_reset_n,
  input wire logic user_port_out,
  input wire logic user_port_oe,
  input wire dfp_pkg::dfp_fcmd_t flash_cmd,
  input wire logic flash_cmd_start,
  input wire logic flash_byte_wr,
  input wire logic [7:0] debug_address_select
);
  timeunit 1ns;
  timeprecision 1ns;
  import dfp_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // four cycles out of halt let any edge still in the synchroniser die
  sequence idle4;
    !halted [*4];
  endsequence
  oe_pass_a: assert property (
    !halted |-> debug_link_data_oe == user_port_oe) else $error("oe pass");
  out_pass_a: assert property (
    !halted |-> debug_link_data_out == user_port_out) else $error("out pass");
  reset_held_a: assert property (
    halted |-> user_reset_n) else $error("user reset in halt");
  start_pulse_a: assert property (
    flash_cmd_start |=> !flash_cmd_start) else $error("start width");
  start_cmd_a: assert property (
    flash_cmd_start |-> flash_cmd != DFP_FC_NONE) else $error("start cmd");
  byte_pulse_a: assert property (
    flash_byte_wr |=> !flash_byte_wr) else $error("byte width");
  quiet_run_a: assert property (
    idle4 |-> !(flash_cmd_start || flash_byte_wr)) else $error("link run");
  addr_hold_a: assert property (
    idle4 |-> $stable(debug_address_select)) else $error("addr moved");
  // out of halt the user reset follows the pin through two flip-flops
  user_rst_a: assert property (
    !halted |-> user_reset_n == $past(debug_link_clock, 2))
    else $error("user reset path");
endmodule
bind dfp_debug_port dfp_debug_port_props u_props (.*);

// [bench/dfp_host_model.sv]
// host adapter model on the two-wire debug link
module dfp_host_model (
  output logic ck,
  output logic dq,
  input wire logic pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ck = 1'b0;
    dq = 1'b1;
  end
  // clock stands low between frames; a released line toggles each bit
  task automatic frame(input logic [1:0] ins, input logic [7:0] wd,
                       output logic [7:0] rd);
    logic [10:0] seq;
    seq = {wd, ins, 1'b0};
    for (int i = 0; i < 12; i++) begin
      if (!ins[0] && i > 2) dq = ~dq;
      else dq = (i < 11) ? seq[i] : 1'b1;
      #400 ck = 1'b1;
      if (i > 2 && i < 11) rd[i-3] = pin;
      #400 ck = 1'b0;
    end
    #400;
  endtask
  // parks the clock pin at a level between frames
  task automatic park_clock(input logic v);
    ck = v;
  endtask
endmodule

// [bench/testbench.sv]
// self-checking bench for the debug flash data port
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import dfp_pkg::*;
  logic mclk = 1'b0, arst_n = 1'b0, halted = 1'b1, uo = 1'b0, uoe = 1'b0;
  logic rdv = 1'b0, done = 1'b0, ck, dq, dout, doe, urn, uin, fcs, fbw;
  logic [7:0] fb, adr, r, wb, rdb = 8'h00;
  dfp_fcmd_t fc;
  int err_total = 0, cmp_count = 0, n_st = 0;
  wire pin = doe ? dout : dq;
  always #50 mclk = ~mclk;
  dfp_host_model host (.ck(ck), .dq(dq), .pin(pin));
  dfp_debug_port DUT (.mclk(mclk), .arst_n(arst_n), .halted(halted),
    .debug_link_clock(ck), .debug_link_data_in(pin),
    .debug_link_data_out(dout), .debug_link_data_oe(doe),
    .user_reset_n(urn), .user_port_out(uo), .user_port_oe(uoe),
    .user_port_in(uin), .flash_cmd(fc), .flash_cmd_start(fcs),
    .flash_byte(fb), .flash_byte_wr(fbw), .flash_rd_valid(rdv),
    .flash_rd_byte(rdb), .flash_cmd_done(done),
    .debug_address_select(adr));
  always @(posedge mclk) begin
    if (fcs) n_st++;
    if (fbw) wb = fb;
  end
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic [7:0] exp_cmd(input logic [7:0] b);
    case (b)
      DFP_CMD_BLOCK_READ: return 8'(DFP_FC_READ);
      DFP_CMD_BLOCK_WRITE: return 8'(DFP_FC_WRITE);
      DFP_CMD_PAGE_ERASE: return 8'(DFP_FC_PAGE_ERASE);
      DFP_CMD_DEVICE_ERASE: return 8'(DFP_FC_DEVICE_ERASE);
      default: return 8'(DFP_FC_NONE);
    endcase
  endfunction
  initial begin
    #1000000;
    err_total++;
    end_sim;
  end
  initial begin
    logic [7:0] cmds [5];
    logic [7:0] b;
    int n;
    void'($urandom(78));
    repeat (16) @(posedge mclk);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge mclk);
    chk("adr_rst", DFP_RST_ADDR_SEL, adr);
    host.frame(2'h3, DFP_ADDR_FLASH_DATA, r);
    host.frame(2'h2, 8'h00, r);
    chk("adr_rd", DFP_ADDR_FLASH_DATA, r);
    host.frame(2'h0, 8'h00, r);
    chk("dat_rst", DFP_RST_FLASH_DATA, r);
    cmds = '{DFP_CMD_BLOCK_READ, DFP_CMD_BLOCK_WRITE, DFP_CMD_PAGE_ERASE,
             DFP_CMD_DEVICE_ERASE, 8'h09};
    for (int k = 0; k < 5; k++) begin
      b = cmds[k];
      n = n_st;
      host.frame(2'h1, b, r);
      chk("cmd", exp_cmd(b), 8'(fc));
      chk("start", 8'(k < 4), 8'(n_st - n));
      b = 8'($urandom);
      host.frame(2'h1, b, r);
      host.frame(2'h0, 8'h00, r);
      chk("dat", b, r);
      if (k < 4) chk("byte", b, wb);
      @(posedge mclk) #1 done = 1'b1;
      @(posedge mclk) #1 done = 1'b0;
    end
    b = 8'($urandom);
    @(posedge mclk) #1 rdv = 1'b1;
    rdb = b;
    @(posedge mclk) #1 rdv = 1'b0;
    host.frame(2'h0, 8'h00, r);
    chk("rd_load", b, r);
    host.frame(2'h3, 8'h5a, r);
    host.frame(2'h0, 8'h00, r);
    chk("unmap", DFP_UNMAPPED_VAL, r);
    n = n_st;
    host.frame(2'h1, DFP_CMD_BLOCK_WRITE, r);
    chk("no_start", 8'h00, 8'(n_st - n));
    host.frame(2'h3, DFP_ADDR_FLASH_DATA, r);
    host.frame(2'h0, 8'h00, r);
    chk("wr_unmap", b, r);
    // leave halt in mid-frame: the cut address write must not land
    fork
      host.frame(2'h3, 8'h11, r);
      begin
        repeat (40) @(posedge mclk);
        #1 halted = 1'b0;
      end
    join
    @(posedge mclk) #1 halted = 1'b1;
    host.frame(2'h2, 8'h00, r);
    chk("cut", DFP_ADDR_FLASH_DATA, r);
    @(posedge mclk) #1 halted = 1'b0;
    uo = 1'b1;
    uoe = 1'b1;
    host.frame(2'h3, 8'h5a, r);
    chk("adr_hold", DFP_ADDR_FLASH_DATA, adr);
    chk("pass", 8'h03, {6'h0, doe, dout});
    chk("urst_lo", 8'h02, {6'h0, uin, urn});
    #1 host.park_clock(1'b1);
    repeat (4) @(posedge mclk);
    chk("urst_hi", 8'h01, {7'h0, urn});
    end_sim;
  end
endmodule
